// [hdl/optical_module_mgmt_port.sv]
// Two-wire management target of a pluggable optical module with paged upper half.
`timescale 1ns/1ps
`include "optical_mgmt_map.svh"
module optical_module_mgmt_port #(
  parameter int NUM_TABLES = 2
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        srst,
  // Module pins.
  input  wire logic        moduleSelectLowInput,
  input  wire logic        powerDownReset,
  // Two-wire serial pins; the data line is open drain.
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Status towards the module's power and page logic.
  output logic             lowPower,
  output logic [7:0]       tableSelect,
  output optical_mgmt_pkg::serial_state_type state
);
  import optical_mgmt_pkg::*;

  localparam int MEM_DEPTH = `HALF_SIZE * (1 + NUM_TABLES);
  localparam int IDX_W     = $clog2(MEM_DEPTH);

  // Pin synchronisers; only the second stage and its delayed copy feed logic.
  logic sclMeta, sclSync, sclPrev;
  logic sdaMeta, sdaSync, sdaPrev;
  logic selMeta, selSync;
  logic pdMeta, pdSync, pdPrev;

  logic [7:0] mem [0:MEM_DEPTH-1];
  logic [7:0] shift;
  logic [7:0] txByte;
  logic [7:0] ptr;
  logic [3:0] bitCnt;
  logic       rw;
  logic       firstByte;
  logic       masterAck;

  always_ff @(posedge clk) begin
    if (srst) begin
      {sclMeta, sclSync, sclPrev} <= 3'h7;
      {sdaMeta, sdaSync, sdaPrev} <= 3'h7;
      {selMeta, selSync} <= 2'h3;
      {pdMeta, pdSync, pdPrev} <= 3'h0;
    end else begin
      {sclMeta, sclSync, sclPrev} <= {scl, sclMeta, sclSync};
      {sdaMeta, sdaSync, sdaPrev} <= {sdaIn, sdaMeta, sdaSync};
      {selMeta, selSync} <= {moduleSelectLowInput, selMeta};
      {pdMeta, pdSync, pdPrev} <= {powerDownReset, pdMeta, pdSync};
    end
  end

  // A falling power-down edge acts like a power cycle on all control state.
  wire pdFall   = pdPrev & ~pdSync;
  wire rstInt   = srst | pdFall;
  wire selected = ~selSync;
  wire sclRise  = sclSync & ~sclPrev;
  wire sclFall  = ~sclSync & sclPrev;
  wire startSeen = sclSync & sclPrev & sdaPrev & ~sdaSync;
  wire stopSeen  = sclSync & sclPrev & ~sdaPrev & sdaSync;
  wire byteDone  = (bitCnt == `BITS_PER_BYTE);

  // Lower half maps straight through; upper half is offset by the selected table.
  function automatic logic [IDX_W:0] mapIndex(input logic [7:0] a, input logic [7:0] tbl);
    logic [31:0] full;
    full = 32'(a[6:0]);
    if (a[7]) begin
      full = 32'(`HALF_SIZE) * (32'(tbl) + 32'h1) + 32'(a[6:0]);
    end
    mapIndex = {(full < 32'(MEM_DEPTH)), full[IDX_W-1:0]};
  endfunction

  wire [IDX_W:0]   mapped  = mapIndex(ptr, tableSelect);
  wire             idxOk   = mapped[IDX_W];
  wire [IDX_W-1:0] memIdx  = mapped[IDX_W-1:0];
  wire             tselHit = (ptr == `TABLE_SEL_ADDR);
  wire [7:0]       rdData  = tselHit ? tableSelect : (idxOk ? mem[memIdx] : `UNMAPPED_READ);
  wire             busy    = ~selected | stopSeen | startSeen;
  wire             wrEn    = ~rstInt & ~busy & sclFall & (state == RX) & byteDone & ~firstByte;

  // Low-power mode only gates the module's power; the target logic keeps running.
  always_ff @(posedge clk) begin
    if (rstInt) begin
      lowPower <= 1'b0;
    end else begin
      lowPower <= pdSync;
    end
  end

  always_ff @(posedge clk) begin
    if (wrEn && idxOk) begin
      mem[memIdx] <= shift;
    end
  end

  always_ff @(posedge clk) begin
    if (rstInt) begin
      tableSelect <= `TABLE_SEL_RESET;
    end else if (wrEn && tselHit) begin
      tableSelect <= shift;
    end
  end

  always_ff @(posedge clk) begin
    if (rstInt) begin
      state     <= IDLE;
      sdaOut    <= 1'b0;
      sdaOe     <= 1'b0;
      shift     <= 8'h00;
      txByte    <= 8'h00;
      ptr       <= 8'h00;
      bitCnt    <= 4'h0;
      rw        <= 1'b0;
      firstByte <= 1'b0;
      masterAck <= 1'b0;
    end else if (!selected || stopSeen) begin
      state <= IDLE;
      sdaOe <= 1'b0;
    end else if (startSeen) begin
      state     <= ADDR;
      sdaOe     <= 1'b0;
      bitCnt    <= 4'h0;
      firstByte <= 1'b1;
    end else if (sclRise) begin
      if (state == ADDR || state == RX) begin
        shift  <= {shift[6:0], sdaSync};
        bitCnt <= bitCnt + 4'h1;
      end else if (state == TX) begin
        bitCnt <= bitCnt + 4'h1;
      end else if (state == TX_ACK) begin
        masterAck <= ~sdaSync;
      end
    end else if (sclFall) begin
      unique case (state)
        IDLE: begin
        end
        ADDR: begin
          if (byteDone && shift[7:1] == `TARGET_ADDR) begin
            state <= ADDR_ACK;
            sdaOe <= 1'b1;
            rw    <= shift[0];
          end else if (byteDone) begin
            state <= IDLE;
          end
        end
        ADDR_ACK: begin
          bitCnt <= 4'h0;
          state  <= rw ? TX : RX;
          txByte <= rdData;
          sdaOe  <= rw & ~rdData[7];
        end
        RX: begin
          if (byteDone) begin
            state     <= RX_ACK;
            sdaOe     <= 1'b1;
            firstByte <= 1'b0;
            ptr       <= firstByte ? shift : ptr + 8'h1;
          end
        end
        RX_ACK: begin
          state  <= RX;
          sdaOe  <= 1'b0;
          bitCnt <= 4'h0;
        end
        TX: begin
          if (byteDone) begin
            state <= TX_ACK;
            sdaOe <= 1'b0;
            ptr   <= ptr + 8'h1;
          end else begin
            sdaOe  <= ~txByte[6];
            txByte <= {txByte[6:0], 1'b0};
          end
        end
        TX_ACK: begin
          bitCnt <= 4'h0;
          state  <= masterAck ? TX : IDLE;
          txByte <= rdData;
          sdaOe  <= masterAck & ~rdData[7];
        end
      endcase
    end
  end

  // The host keeps select low throughout a transfer; a lapse aborts it.

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  lowpower_follow_a: assert property (pdSync && !pdFall |=> lowPower)
    else $error("low power not entered");
  mgmt_start_a: assert property (startSeen && selected && !rstInt
      && !stopSeen |=> state == ADDR)
    else $error("start ignored");
  full_reset_a: assert property (pdFall |=> state == IDLE && !sdaOe
      && tableSelect == `TABLE_SEL_RESET && !lowPower)
    else $error("falling power-down did not reset");
  addr_miss_a: assert property (state == ADDR && sclFall && byteDone && !busy
      && !rstInt && shift[7:1] != `TARGET_ADDR |=> state == IDLE && !sdaOe)
    else $error("foreign address acknowledged");
  desel_quiet_a: assert property (!selected |=> !sdaOe ##1 !sdaOe)
    else $error("data line driven while deselected");
  pullup_level_a: assert property (@(posedge clk) disable iff (1'b0)
      srst |=> !selected)
    else $error("module selected after reset");
  space_bound_a: assert property (ptr[7]
      |-> idxOk == (tableSelect < 8'(NUM_TABLES)))
    else $error("upper half mapping does not follow table count");
  lower_direct_a: assert property (!ptr[7] |-> idxOk && memIdx == IDX_W'(ptr[6:0]))
    else $error("lower half not direct");
  table_write_a: assert property (wrEn && tselHit
      |=> tableSelect == $past(shift) && state == RX_ACK)
    else $error("table select not stored");
  abandon_a: assert property (state != IDLE && !selected && !rstInt
      |=> state == IDLE && !sdaOe)
    else $error("transfer not abandoned");

  read_cov_c:  cover property (state == ADDR_ACK && rw ##[1:300] state == TX_ACK);
  write_cov_c: cover property (wrEn && tselHit);
  desel_cov_c: cover property (state == RX && !selected);
  pd_cov_c:    cover property (lowPower && state == RX_ACK);
endmodule // optical_module_mgmt_port

// [shared/optical_mgmt_map.svh]
// Constants of the optical module management port: address, map layout, reset values.
`ifndef OPTICAL_MGMT_MAP_SVH
`define OPTICAL_MGMT_MAP_SVH
`define TARGET_ADDR      7'h50
`define TABLE_SEL_ADDR   8'h7f
`define TABLE_SEL_RESET  8'h00
`define HALF_SIZE        128
`define BITS_PER_BYTE    4'h8
`define UNMAPPED_READ    8'hff
`endif

// [shared/optical_mgmt_pkg.sv]
// Types of the optical module management port.
package optical_mgmt_pkg;
  typedef enum logic [2:0] {
    IDLE     = 3'b000,
    ADDR     = 3'b001,
    ADDR_ACK = 3'b011,
    RX       = 3'b010,
    RX_ACK   = 3'b110,
    TX       = 3'b111,
    TX_ACK   = 3'b101
  } serial_state_type;
endpackage

// [test/host_bus_model.sv]
// Behavioural host controller for the two-wire management bus.
`timescale 1ns/1ps
module host_bus_model (
  // Clock.
  input  wire logic clk,
  // Wire pins.
  input  wire logic sdaOut,
  input  wire logic sdaOe,
  output logic      scl,
  output wire logic sdaIn
);
  logic hostLow;
  // The board pull-up holds the line high unless a party pulls it low.
  assign sdaIn = ~hostLow & (sdaOe ? sdaOut : 1'b1);
  initial begin
    scl = 1'b1;
    hostLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One bit: 13 clocks low and 12 high, a 125 ns bus clock.
  task automatic bitx(input logic b, output logic r);
    hostLow = ~b;
    tick(6);
    scl = 1'b1;
    tick(6);
    r = sdaIn;
    tick(6);
    scl = 1'b0;
    tick(7);
  endtask
  task automatic start();
    hostLow = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    hostLow = 1'b1;
    tick(6);
    scl = 1'b0;
    tick(7);
  endtask
  task automatic stop();
    hostLow = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(6);
    hostLow = 1'b0;
    tick(12);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ackIn,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(ackIn, ack);
  endtask
endmodule // host_bus_model

// [test/test_optical_module_mgmt_port.sv]
// Self-checking bench of the optical module management port.
`timescale 1ns/1ps
module test_optical_module_mgmt_port;
  import optical_mgmt_pkg::*;
  logic clk, srst, sel, pd;
  logic scl, sdaIn, sdaOut, sdaOe, lowPower, a;
  logic [7:0] tableSelect, q;
  serial_state_type state;
  int n_errors = 0, checked = 0;
  logic [15:0] rows [4] = '{16'h00a5, 16'h7e3c, 16'h805a, 16'hffc3};
  always #2.5 clk = ~clk;
  optical_module_mgmt_port dut (.clk(clk), .srst(srst), .moduleSelectLowInput(sel),
    .powerDownReset(pd), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .lowPower(lowPower), .tableSelect(tableSelect), .state(state));
  host_bus_model host (.clk(clk), .sdaOut(sdaOut), .sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn));
  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpBit(input logic got, input logic exp);
    cmpByte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    logic [7:0] r;
    logic ak;
    host.start();
    host.xfer(8'ha0, 1'b1, r, ak);
    cmpBit(ak, 1'b0);
    host.xfer(off, 1'b1, r, ak);
    host.xfer(d, 1'b1, r, ak);
    cmpBit(ak, 1'b0);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] off, output logic [7:0] r);
    logic ak;
    host.start();
    host.xfer(8'ha0, 1'b1, r, ak);
    host.xfer(off, 1'b1, r, ak);
    host.start();
    host.xfer(8'ha1, 1'b1, r, ak);
    host.xfer(8'hff, 1'b1, r, ak);
    host.stop();
  endtask
  task automatic waitLp(input logic v);
    int n;
    n = 0;
    while (lowPower !== v && n < 20) begin
      host.tick(1);
      n++;
    end
    cmpBit(lowPower, v);
    if (n == 20)
      tally_and_finish();
  endtask
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    sel = 1'b1;
    pd = 1'b0;
    host.tick(6);
    srst = 1'b0;
    cmpByte(tableSelect, 8'h00);
    cmpByte({5'h00, state}, {5'h00, IDLE});
    $display("Test reset done");
    sel = 1'b0;
    host.tick(4);
    foreach (rows[i]) begin
      wr(rows[i][15:8], rows[i][7:0]);
      rd(rows[i][15:8], q);
      cmpByte(q, rows[i][7:0]);
    end
    $display("Test rows done");
    wr(8'h7f, 8'h01);
    cmpByte(tableSelect, 8'h01);
    wr(8'h80, 8'h77);
    rd(8'h80, q);
    cmpByte(q, 8'h77);
    rd(8'h00, q);
    cmpByte(q, 8'ha5);
    wr(8'h7f, 8'h02);
    wr(8'h80, 8'h11);
    rd(8'h80, q);
    cmpByte(q, 8'hff);
    wr(8'h7f, 8'h00);
    rd(8'h80, q);
    cmpByte(q, 8'h5a);
    $display("Test paging done");
    host.start();
    host.xfer(8'ha2, 1'b1, q, a);
    cmpBit(a, 1'b1);
    host.stop();
    sel = 1'b1;
    host.tick(4);
    host.start();
    host.xfer(8'ha0, 1'b1, q, a);
    cmpBit(a, 1'b1);
    host.stop();
    sel = 1'b0;
    host.tick(4);
    $display("Test refusals done");
    // Pointer now rests on the select byte, zero, so the target drives low.
    rd(8'h7e, q);
    host.start();
    host.xfer(8'ha1, 1'b1, q, a);
    cmpBit(sdaOe, 1'b1);
    cmpBit(sdaOut, 1'b0);
    sel = 1'b1;
    host.tick(8);
    cmpBit(sdaOe, 1'b0);
    cmpByte({5'h00, state}, {5'h00, IDLE});
    host.stop();
    sel = 1'b0;
    host.tick(4);
    $display("Test abort done");
    pd = 1'b1;
    waitLp(1'b1);
    wr(8'h01, 8'h69);
    rd(8'h01, q);
    cmpByte(q, 8'h69);
    wr(8'h7f, 8'h01);
    pd = 1'b0;
    waitLp(1'b0);
    host.tick(8);
    cmpByte(tableSelect, 8'h00);
    rd(8'h00, q);
    cmpByte(q, 8'ha5);
    $display("Test power done");
    tally_and_finish();
  end
endmodule // test_optical_module_mgmt_port
